// File: adc_channel_config_register.sv
// AHB-Lite slave holding one channel configuration register.
// Assumes a single master; responses are always OKAY, zero wait.
`timescale 1ns/1ns

module adc_channel_config_register (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [7:0]   haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Global filter setting from the device core
  input  wire logic         global_setting_a,
  // Channel controls
  output chcfg_pkg::ch_ctrl_type ch_ctrl,
  output chcfg_pkg::route_type   ch_route,
  output logic                   ch_global_setting_a_on
);

  // ==========================================================
  // Helpers
  function automatic chcfg_pkg::route_type decode_sel(
    input logic [1:0] code);
    chcfg_pkg::route_type r;
    r = '0;
    unique case (chcfg_pkg::input_sel_type'(code))
      chcfg_pkg::sel_pins:   r.pins = 1'b1;
      chcfg_pkg::sel_short:  r.shorted = 1'b1;
      chcfg_pkg::sel_pos_dc: r.pos_dc = 1'b1;
      chcfg_pkg::sel_neg_dc: r.neg_dc = 1'b1;
    endcase
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] a);
    return a == chcfg_pkg::cfg_offset;
  endfunction

  // Address phase taken this edge; NONSEQ and SEQ both have bit 1 set
  function automatic logic is_req(
    input logic       sel,
    input logic       rdy,
    input logic [1:0] trans);
    return sel && rdy && trans[1];
  endfunction

  // ==========================================================
  // State
  chcfg_pkg::state_type s_q;
  chcfg_pkg::state_type s_d;
  logic                 req;
  logic [15:0]          cfg_d;

  assign req = is_req(hsel, hready, htrans);

  always_comb begin
    s_d = s_q;
    cfg_d = s_q.cfg;
    // ========================================================
    // Write path
    // Write data arrives one cycle after its address phase, so the
    // pending flag and address decide the store.
    if (s_q.wr_pend && hit(s_q.wr_addr)) begin
      // Reserved bits are dropped here rather than stored
      cfg_d = hwdata[15:0] & chcfg_pkg::cfg_wmask;
    end
    s_d.cfg = cfg_d;
    s_d.wr_pend = req && hwrite;
    s_d.wr_addr = haddr;
    // ========================================================
    // Read path
    if (req && !hwrite) begin
      // A read right after a write sees the new word, since cfg_d
      // already holds it; unmapped words read zero.
      s_d.hrdata = hit(haddr) ? {16'h0000, cfg_d} : 32'h0000_0000;
    end
    // ========================================================
    // Analog-side controls, registered so they change together
    s_d.route = decode_sel(cfg_d[chcfg_pkg::sel_msb:chcfg_pkg::sel_lsb]);
    // The bypass only ever turns the filter off; it cannot force it on
    s_d.global_setting_a_on = global_setting_a
                     && !cfg_d[chcfg_pkg::bypass_bit];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{cfg:        chcfg_pkg::cfg_reset,
               wr_pend:    1'b0,
               wr_addr:    8'h00,
               hrdata:     32'h0000_0000,
               route:      '{pins: 1'b1, default: 1'b0},
               global_setting_a_on: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.hrdata;
  // Field order of the control bundle follows the register, msb first
  assign ch_ctrl   = chcfg_pkg::ch_ctrl_type'({
    s_q.cfg[chcfg_pkg::phase_msb:chcfg_pkg::phase_lsb],
    s_q.cfg[chcfg_pkg::bypass_bit],
    s_q.cfg[chcfg_pkg::sel_msb:chcfg_pkg::sel_lsb]});
  assign ch_route  = s_q.route;
  assign ch_global_setting_a_on = s_q.global_setting_a_on;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A write is an address phase, then a data phase, then the stored word
  sequence wr_to_cfg;
    is_req(hsel, hready, htrans) && hwrite && hit(haddr);
  endsequence

  sequence wr_elsewhere;
    is_req(hsel, hready, htrans) && hwrite && !hit(haddr);
  endsequence

  sequence rd_of_cfg;
    is_req(hsel, hready, htrans) && !hwrite && hit(haddr) && !s_q.wr_pend;
  endsequence

  sequence rd_elsewhere;
    is_req(hsel, hready, htrans) && !hwrite && !hit(haddr);
  endsequence

  sequence no_read;
    !(is_req(hsel, hready, htrans) && !hwrite);
  endsequence

  a_phase_write: assert property (
    wr_to_cfg |=> ##1
      s_q.cfg[chcfg_pkg::phase_msb:chcfg_pkg::phase_lsb]
        == $past(hwdata[chcfg_pkg::phase_msb:chcfg_pkg::phase_lsb]))
    else $error("phase delay not stored");

  a_masked_store: assert property (
    wr_to_cfg |=> ##1
      s_q.cfg == ($past(hwdata[15:0]) & chcfg_pkg::cfg_wmask))
    else $error("written word not stored under mask");

  a_unmapped_write: assert property (
    wr_elsewhere |=> ##1 $stable(s_q.cfg))
    else $error("unmapped write changed the register");

  a_reserved_zero: assert property (
    s_q.cfg[5:3] == 3'h0 && hrdata[31:16] == 16'h0000)
    else $error("reserved bits not zero");

  a_unmapped_read: assert property (
    rd_elsewhere |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (
    no_read |=> $stable(hrdata))
    else $error("read data moved without a read");

  a_bypass_global: assert property (
    ##1 ch_global_setting_a_on
      == ($past(global_setting_a) && !s_q.cfg[chcfg_pkg::bypass_bit]))
    else $error("dc block follow wrong");

  a_bypass_off: assert property (
    s_q.cfg[chcfg_pkg::bypass_bit] |-> !ch_global_setting_a_on)
    else $error("bypassed channel still filtered");

  a_sel_pins: assert property (
    s_q.cfg[1:0] == chcfg_pkg::sel_pins |-> ch_route == 4'h8)
    else $error("pins not routed");

  a_sel_short: assert property (
    s_q.cfg[1:0] == chcfg_pkg::sel_short |-> ch_route == 4'h4)
    else $error("inputs not shorted");

  a_route_onehot: assert property (
    $onehot(ch_route))
    else $error("input routing not one-hot");

  a_sel_test: assert property (
    s_q.cfg[1] |-> ch_route.pos_dc == !s_q.cfg[0]
                   && ch_route.neg_dc == s_q.cfg[0])
    else $error("test signal wrong");

  a_ctrl_fields: assert property (
    ch_ctrl.ch_phase_delay
        == s_q.cfg[chcfg_pkg::phase_msb:chcfg_pkg::phase_lsb]
      && ch_ctrl.ch_global_setting_a_bypass == s_q.cfg[chcfg_pkg::bypass_bit]
      && ch_ctrl.ch_input_select
        == s_q.cfg[chcfg_pkg::sel_msb:chcfg_pkg::sel_lsb])
    else $error("control bundle does not match register");

  a_read_back: assert property (
    rd_of_cfg |=> hrdata[15:0] == $past(s_q.cfg))
    else $error("read data mismatch");

  a_reset_value: assert property (
    $rose(hresetn) |-> s_q.cfg == chcfg_pkg::cfg_reset)
    else $error("reset value wrong");

endmodule

// File: adc_channel_config_register_tb.sv
// Self-checking bench for the channel configuration register.
// Assumes a zero-wait, always-OKAY slave with hready fed from hreadyout.
`timescale 1ns/1ns
module adc_channel_config_register_tb;
  logic                   hclk, hresetn, hsel, hwrite, gs;
  logic                   hreadyout, hresp, dc_on;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [7:0]             haddr, a;
  logic [15:0]            m;
  logic [31:0]            hwdata, hrdata, rd, d, l;
  chcfg_pkg::ch_ctrl_type ctrl;
  chcfg_pkg::route_type   route;
  int                     num_errors, total_checks;

  adc_channel_config_register u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .global_setting_a(gs), .ch_ctrl(ctrl),
    .ch_route(route), .ch_global_setting_a_on(dc_on));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // Reserved bits 5:3 never stick
  function automatic logic [15:0] exp_cfg(input logic [31:0] v);
    return v[15:0] & 16'hffc7;
  endfunction

  task check(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Entered just after a rising edge; waits on hready, never a fixed count
  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    htrans <= chcfg_pkg::htrans_nonseq;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  initial begin
    repeat (3000) @(posedge hclk);
    num_errors++;
    complete_run;
  end

  initial begin
    {hresetn, hsel, hwrite, gs, htrans, haddr, hwdata, m} = '0;
    hsize = 3'h2;
    l = 32'he1d1;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Look between edges so the reset values are not raced
    @(negedge hclk);
    check("rst_route", 32'h8, route);
    check("rst_ctrl", 32'h0, ctrl);
    check("rst_global_setting_a", 32'h0, {31'h0, dc_on});
    check("rst_rdata", 32'h0, hrdata);
    @(posedge hclk);
    for (int i = 0; i < 40; i++) begin
      l = lfsr(l);
      d = (i == 1) ? 32'hffffffff : (i == 2) ? 32'h00008000 : l;
      d[1:0] = i[1:0];
      d[5:3] = 3'h0;
      a = (i % 5 == 4) ? 8'h04 : chcfg_pkg::cfg_offset;
      gs <= l[7];
      xfer(1'b1, a, d);
      if (a == chcfg_pkg::cfg_offset) m = exp_cfg(d);
      @(negedge hclk);
      check("ctrl", {19'h0, m[15:6], m[2:0]}, ctrl);
      check("route", 32'h8 >> m[1:0], route);
      check("global_setting_a", {31'h0, gs & ~m[2]}, {31'h0, dc_on});
      @(posedge hclk);
      xfer(1'b0, a, 32'h0);
      check("rdata", (a == 8'h0) ? {16'h0, m} : 32'h0, rd);
      check("hresp", 32'h0, {31'h0, hresp});
    end
    complete_run;
  end
endmodule

// File: chcfg_pkg.sv
// Package for the channel configuration register block.
// Assumes a 32-bit AHB-Lite bus with one aligned word per register.
package chcfg_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] cfg_offset = 8'h00;
  localparam logic [15:0] cfg_reset = 16'h0000;
  localparam logic [15:0] cfg_wmask = 16'hffc7;

  // ==========================================================
  // Field layout
  localparam int phase_lsb  = 6;
  localparam int phase_msb  = 15;
  localparam int bypass_bit = 2;
  localparam int sel_msb    = 1;
  localparam int sel_lsb    = 0;

  // ==========================================================
  // Input selector codes
  typedef enum logic [1:0] {
    sel_pins   = 2'h0,
    sel_short  = 2'h1,
    sel_pos_dc = 2'h2,
    sel_neg_dc = 2'h3
  } input_sel_type;

  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [1:0] htrans_seq    = 2'h3;

  // Channel controls as seen by the analog side
  typedef struct packed {
    logic [9:0]    ch_phase_delay;
    logic          ch_global_setting_a_bypass;
    input_sel_type ch_input_select;
  } ch_ctrl_type;

  // Decoded input routing, one-hot
  typedef struct packed {
    logic pins;
    logic shorted;
    logic pos_dc;
    logic neg_dc;
  } route_type;

  typedef struct packed {
    logic [15:0] cfg;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    route_type   route;
    logic        global_setting_a_on;
  } state_type;

endpackage
